// File: logic/dmacs_top.sv
`include "dmacs_defines.svh"

// Function
// (RULE1) A written force bit makes the enabled channel do exactly one transfer.
// (RULE2) With force clear, the selected peripheral request starts each transfer.
// (RULE3) Writing zero cannot clear force; hardware clears it after the forced transfer.
// (RULE4) Seven-bit request number picks one of 128 request lines.
// (RULE5) Each channel holds a 16-bit primary RAM start offset.
// (RULE6) Each channel holds a 16-bit secondary RAM start offset.
// (RULE7) Each channel holds a 16-bit peripheral address used for transfers.
// (RULE8) Software avoids writing peripheral address or count while channel is enabled.
// (RULE9) Ten-bit transfer count; each block moves count plus one transfers.
// (RULE10) Count bits 15-10 and request-select bits 14-7 read as zero.
// (RULE11) Peripheral write collision flag of channel n sits at status bit 8+n.
// (RULE12) RAM write collision flag of channel n sits at status bit n.
// (RULE13) Collision flags reset to zero, stay until cleared, software cannot set.
// (RULE14) All writable configuration fields reset to zero.
// (RULE15) A channel transfers only while its enable bit is set; a request already pending when it clears can still be granted.
// (RULE16) Ping-pong mode alternates primary and secondary offsets on successive blocks.
// (RULE17) Per-channel interrupt pulse at block end, or optionally at half block.
// (RULE18) Addressing mode 00 increments the RAM address after each transfer.
module dmacs_top (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst_n,
    // Register bus
    input wire dmacs_pkg::dmacs_bus_type i_bus,
    output logic [15:0] o_rdata,
    // Peripheral request lines
    input wire logic [127:0] i_periph_req,
    // Transfer port
    output dmacs_pkg::dmacs_xfer_type o_xfer,
    input wire logic i_xfer_ack,
    // Collision events
    input wire logic [7:0] i_periph_wcol,
    input wire logic [7:0] i_ram_wcol,
    // Block interrupt requests
    output logic [7:0] o_block_irq
);

    localparam int NCH = dmacs_pkg::CHANNELS;

    function automatic logic [7:0] ch_onehot(input logic [2:0] ch);
        ch_onehot = 8'h01 << ch;
    endfunction

    function automatic logic [2:0] lowest_set(input logic [7:0] v);
        logic [2:0] idx;
        idx = 3'h0;
        for (int i = NCH - 1; i >= 0; i--) begin
            if (v[i]) begin
                idx = 3'(i);
            end
        end
        lowest_set = idx;
    endfunction

    // Per-channel configuration
    dmacs_pkg::dmacs_ctrl_type ctrl_q [NCH];
    logic [6:0] reqnum_q [NCH];
    logic [NCH-1:0] force_q;
    logic [15:0] pstart_q [NCH];
    logic [15:0] sstart_q [NCH];
    logic [15:0] paddr_q [NCH];
    logic [9:0] count_q [NCH];

    // Shared status and outputs
    logic [15:0] coll_q;
    logic [15:0] rdata_q;
    logic [7:0] irq_q;
    dmacs_pkg::dmacs_xfer_type xfer_q;
    dmacs_pkg::dmacs_xfer_type xfer_d;
    dmacs_pkg::dmacs_state_type state_q;
    dmacs_pkg::dmacs_state_type state_d;

    // Channel status
    logic [NCH-1:0] pending;
    logic [NCH-1:0] pp_sel;
    logic [NCH-1:0] irq_vec;
    logic [NCH-1:0] oneshot_end;
    logic [NCH-1:0] sel_req;
    logic [15:0] ram_addr [NCH];
    logic [15:0] chan_rd [NCH];

    // Bus decode
    wire in_chan_win = !i_bus.addr[6];
    wire [2:0] bus_ch = i_bus.addr[5:3];
    wire [2:0] bus_reg = i_bus.addr[2:0];
    wire [7:0] wr_ch = (i_bus.wr && in_chan_win) ? ch_onehot(bus_ch) : 8'h00;
    wire wr_ctrl = bus_reg == `DMACS_REG_CTRL;
    wire wr_reqsel = bus_reg == `DMACS_REG_REQSEL;
    wire wr_pstart = bus_reg == `DMACS_REG_PSTART;
    wire wr_sstart = bus_reg == `DMACS_REG_SSTART;
    wire wr_paddr = bus_reg == `DMACS_REG_PADDR;
    wire wr_count = bus_reg == `DMACS_REG_COUNT;
    wire wr_coll = i_bus.wr && (i_bus.addr == `DMACS_ADDR_COLL);

    // Transfer completion per channel
    wire busy = state_q == dmacs_pkg::DMACS_BUSY;
    wire [7:0] done_vec = (busy && i_xfer_ack) ? ch_onehot(xfer_q.channel) : 8'h00;

    // Control word unpacked from write data
    dmacs_pkg::dmacs_ctrl_type ctrl_wr;
    assign ctrl_wr.on = i_bus.wdata[`DMACS_ON_BIT];
    assign ctrl_wr.to_periph = i_bus.wdata[`DMACS_DIR_BIT];
    assign ctrl_wr.half = i_bus.wdata[`DMACS_HALF_BIT];
    assign ctrl_wr.addressing_mode = i_bus.wdata[`DMACS_ADDRESSING_MODE_LSB +: 2];
    assign ctrl_wr.mode = i_bus.wdata[`DMACS_MODE_LSB +: 2];

    generate
        for (genvar g = 0; g < NCH; g++) begin : g_chan
            wire wr_here = wr_ch[g];
            wire force_set = wr_here && wr_reqsel && i_bus.wdata[`DMACS_FORCE_BIT];
            wire [15:0] ctrl_word = {ctrl_q[g].on, 1'b0, ctrl_q[g].to_periph, ctrl_q[g].half,
                                     6'h00, ctrl_q[g].addressing_mode, 2'h0, ctrl_q[g].mode};
            wire [15:0] reqsel_word = {force_q[g], 8'h00, reqnum_q[g]}; // [RULE10]
            wire [15:0] count_word = {6'h00, count_q[g]}; // [RULE10]

            assign sel_req[g] = i_periph_req[reqnum_q[g]]; // [RULE4]

            assign chan_rd[g] = wr_ctrl ? ctrl_word
                              : wr_reqsel ? reqsel_word
                              : wr_pstart ? pstart_q[g]
                              : wr_sstart ? sstart_q[g]
                              : wr_paddr ? paddr_q[g]
                              : wr_count ? count_word
                              : 16'h0000;

            // Write wins over the hardware stop of a one-shot channel
            always_ff @(posedge i_clock or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    ctrl_q[g] <= '0; // [RULE14]
                end else if (wr_here && wr_ctrl) begin
                    ctrl_q[g] <= ctrl_wr;
                end else if (oneshot_end[g]) begin
                    ctrl_q[g].on <= 1'b0;
                end
            end

            // Only hardware clears force; a new set wins over that clear
            always_ff @(posedge i_clock or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    force_q[g] <= 1'b0; // [RULE14]
                end else if (force_set) begin
                    force_q[g] <= 1'b1; // [RULE1] [RULE3]
                end else if (done_vec[g]) begin
                    force_q[g] <= 1'b0; // [RULE3]
                end
            end

            always_ff @(posedge i_clock or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    reqnum_q[g] <= `DMACS_RESET_REQNUM; // [RULE14]
                end else if (wr_here && wr_reqsel) begin
                    reqnum_q[g] <= i_bus.wdata[`DMACS_REQNUM_MSB:0]; // [RULE4]
                end
            end

            always_ff @(posedge i_clock or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    pstart_q[g] <= `DMACS_RESET_WORD; // [RULE14]
                    sstart_q[g] <= `DMACS_RESET_WORD;
                end else begin
                    if (wr_here && wr_pstart) begin
                        pstart_q[g] <= i_bus.wdata; // [RULE5]
                    end
                    if (wr_here && wr_sstart) begin
                        sstart_q[g] <= i_bus.wdata; // [RULE6]
                    end
                end
            end

            always_ff @(posedge i_clock or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    paddr_q[g] <= `DMACS_RESET_WORD; // [RULE14]
                    count_q[g] <= `DMACS_RESET_COUNT;
                end else begin
                    if (wr_here && wr_paddr) begin
                        paddr_q[g] <= i_bus.wdata; // [RULE7]
                    end
                    if (wr_here && wr_count) begin
                        count_q[g] <= i_bus.wdata[`DMACS_COUNT_MSB:0]; // [RULE9]
                    end
                end
            end

            dmacs_channel u_channel (
                .i_clock(i_clock),
                .i_rst_n(i_rst_n),
                .i_ctrl(ctrl_q[g]),
                .i_pstart(pstart_q[g]),
                .i_sstart(sstart_q[g]),
                .i_count(count_q[g]),
                .i_force(force_q[g]),
                .i_req(sel_req[g]),
                .i_done(done_vec[g]),
                .o_pending(pending[g]),
                .o_ram_addr(ram_addr[g]),
                .o_pp_sel(pp_sel[g]),
                .o_irq(irq_vec[g]),
                .o_oneshot_end(oneshot_end[g])
            );
        end
    endgenerate

    // Fixed priority, channel 0 highest
    wire any_pending = |pending;
    wire [2:0] win_ch = lowest_set(pending);

    always_comb begin
        state_d = state_q;
        xfer_d = xfer_q;
        unique case (state_q)
            dmacs_pkg::DMACS_IDLE: begin
                if (any_pending) begin
                    xfer_d.valid = 1'b1;
                    xfer_d.channel = win_ch;
                    xfer_d.to_periph = ctrl_q[win_ch].to_periph;
                    xfer_d.ram_addr = ram_addr[win_ch]; // [RULE5] [RULE18]
                    xfer_d.periph_addr = paddr_q[win_ch]; // [RULE7]
                    state_d = dmacs_pkg::DMACS_BUSY;
                end
            end
            dmacs_pkg::DMACS_BUSY: begin
                if (i_xfer_ack) begin
                    xfer_d.valid = 1'b0;
                    state_d = dmacs_pkg::DMACS_IDLE;
                end
            end
            default: begin
                xfer_d.valid = 1'b0;
                state_d = dmacs_pkg::DMACS_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_q <= dmacs_pkg::DMACS_IDLE;
            xfer_q <= '0;
        end else begin
            state_q <= state_d;
            xfer_q <= xfer_d;
        end
    end

    // Collision flags: events set, writing 0 clears, set wins
    wire [15:0] coll_set = {i_periph_wcol, i_ram_wcol}; // [RULE11] [RULE12]
    wire [15:0] coll_keep = wr_coll ? i_bus.wdata : 16'hffff;
    wire [15:0] coll_d = coll_set | (coll_q & coll_keep); // [RULE13]

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            coll_q <= `DMACS_RESET_WORD; // [RULE13]
        end else begin
            coll_q <= coll_d;
        end
    end

    // Read mux; unmapped addresses read zero
    wire [15:0] rdata_sel = in_chan_win ? chan_rd[bus_ch]
                          : (i_bus.addr == `DMACS_ADDR_COLL) ? coll_q // [RULE11] [RULE12]
                          : (i_bus.addr == `DMACS_ADDR_PPST) ? {8'h00, pp_sel}
                          : 16'h0000;

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rdata_q <= `DMACS_RESET_WORD;
            irq_q <= 8'h00;
        end else begin
            rdata_q <= i_bus.rd ? rdata_sel : 16'h0000;
            irq_q <= irq_vec; // [RULE17]
        end
    end

    assign o_rdata = rdata_q;
    assign o_xfer = xfer_q;
    assign o_block_irq = irq_q;

endmodule // dmacs_top

// File: shared/dmacs_defines.svh
`ifndef DMACS_DEFINES_SVH
`define DMACS_DEFINES_SVH

// Register index inside one channel window
`define DMACS_REG_CTRL 3'h0
`define DMACS_REG_REQSEL 3'h1
`define DMACS_REG_PSTART 3'h2
`define DMACS_REG_SSTART 3'h3
`define DMACS_REG_PADDR 3'h4
`define DMACS_REG_COUNT 3'h5

// Shared status register addresses
`define DMACS_ADDR_COLL 7'h40
`define DMACS_ADDR_PPST 7'h41

// Field positions
`define DMACS_FORCE_BIT 15
`define DMACS_REQNUM_MSB 6
`define DMACS_ON_BIT 15
`define DMACS_DIR_BIT 13
`define DMACS_HALF_BIT 12
`define DMACS_ADDRESSING_MODE_LSB 4
`define DMACS_MODE_LSB 0
`define DMACS_COUNT_MSB 9

// Reset values
`define DMACS_RESET_WORD 16'h0000
`define DMACS_RESET_COUNT 10'h000
`define DMACS_RESET_REQNUM 7'h00

// Addressing
`define DMACS_ADDRESSING_MODE_POSTINC 2'h0
`define DMACS_ADDR_STEP 16'h0002

`endif

// File: shared/dmacs_pkg.sv
package dmacs_pkg;

    localparam int CHANNELS = 8;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [6:0] addr;
        logic [15:0] wdata;
    } dmacs_bus_type;

    typedef struct packed {
        logic valid;
        logic [2:0] channel;
        logic to_periph;
        logic [15:0] ram_addr;
        logic [15:0] periph_addr;
    } dmacs_xfer_type;

    typedef struct packed {
        logic on;
        logic to_periph;
        logic half;
        logic [1:0] addressing_mode;
        logic [1:0] mode;
    } dmacs_ctrl_type;

    typedef enum logic [1:0] {
        DMACS_IDLE = 2'b01,
        DMACS_BUSY = 2'b10
    } dmacs_state_type;

endpackage

// File: logic/dmacs_channel.sv
`include "dmacs_defines.svh"

module dmacs_channel (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst_n,
    // Configuration
    input wire dmacs_pkg::dmacs_ctrl_type i_ctrl,
    input wire logic [15:0] i_pstart,
    input wire logic [15:0] i_sstart,
    input wire logic [9:0] i_count,
    // Triggers and completion
    input wire logic i_force,
    input wire logic i_req,
    input wire logic i_done,
    // Status
    output logic o_pending,
    output logic [15:0] o_ram_addr,
    output logic o_pp_sel,
    output logic o_irq,
    output logic o_oneshot_end
);

    logic pending_q;
    logic pp_q;
    logic [9:0] done_cnt_q;
    logic [15:0] offset_q;

    // Forced request fires once; selected line only when not forced
    wire trig = i_ctrl.on && (i_force ? !pending_q : i_req); // [RULE1] [RULE2] [RULE15]
    wire block_end = i_done && (done_cnt_q == i_count); // [RULE9]
    wire half_point = done_cnt_q == (i_count >> 1);
    wire irq_point = i_ctrl.half ? half_point : (done_cnt_q == i_count);
    wire step = i_ctrl.addressing_mode == `DMACS_ADDRESSING_MODE_POSTINC;
    wire [15:0] base = pp_q ? i_sstart : i_pstart; // [RULE5] [RULE6] [RULE16]

    assign o_pending = pending_q;
    assign o_ram_addr = 16'(base + offset_q);
    assign o_pp_sel = pp_q;
    assign o_irq = i_done && irq_point; // [RULE17]
    assign o_oneshot_end = block_end && i_ctrl.mode[0] && (!i_ctrl.mode[1] || pp_q);

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pending_q <= 1'b0;
            pp_q <= 1'b0;
            done_cnt_q <= `DMACS_RESET_COUNT;
            offset_q <= `DMACS_RESET_WORD;
        end else if (!i_ctrl.on) begin // [RULE15]
            pending_q <= 1'b0;
            pp_q <= 1'b0;
            done_cnt_q <= `DMACS_RESET_COUNT;
            offset_q <= `DMACS_RESET_WORD;
        end else begin
            // A one-shot stop must not leave a stale request for the arbiter
            pending_q <= (trig && !o_oneshot_end) || (pending_q && !i_done); // [RULE15]
            if (i_done) begin
                done_cnt_q <= block_end ? `DMACS_RESET_COUNT : 10'(done_cnt_q + 10'h001); // [RULE9]
                offset_q <= block_end ? `DMACS_RESET_WORD
                          : (step ? 16'(offset_q + `DMACS_ADDR_STEP) : offset_q); // [RULE18]
                if (block_end && i_ctrl.mode[1]) begin
                    pp_q <= !pp_q; // [RULE16]
                end
            end
        end
    end

endmodule // dmacs_channel

// File: dv/dmacs_props.sv
module dmacs_props (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst_n,
    // Design ports
    input wire dmacs_pkg::dmacs_bus_type i_bus,
    input wire logic [15:0] o_rdata,
    input wire logic [127:0] i_periph_req,
    input wire dmacs_pkg::dmacs_xfer_type o_xfer,
    input wire logic i_xfer_ack,
    input wire logic [7:0] i_periph_wcol,
    input wire logic [7:0] i_ram_wcol,
    input wire logic [7:0] o_block_irq
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge i_clock);
    endclocking
    default disable iff (!i_rst_n);
    sequence s_coll_rd;
        i_bus.rd && i_bus.addr == 7'h40;
    endsequence
    sequence s_done;
        o_xfer.valid && i_xfer_ack;
    endsequence
    a_rdata_idle: assert property (!$past(i_bus.rd) |-> o_rdata == 16'h0000)
        else $error("read data not zero outside read");
    a_xfer_hold: assert property (o_xfer.valid && !i_xfer_ack |=> o_xfer.valid && $stable(o_xfer))
        else $error("transfer changed before ack");
    a_xfer_end: assert property (s_done |=> !o_xfer.valid)
        else $error("transfer still valid after ack");
    a_reqsel_zero: assert property ($past(i_bus.rd) && $past(i_bus.addr) < 7'h40
        && $past(i_bus.addr[2:0]) == 3'h1 |-> o_rdata[14:7] == 8'h00) else $error("request select gap not zero");
    a_count_zero: assert property ($past(i_bus.rd) && $past(i_bus.addr) < 7'h40
        && $past(i_bus.addr[2:0]) == 3'h5 |-> o_rdata[15:10] == 6'h00) else $error("count upper bits not zero");
    a_ram_coll: assert property ((|i_ram_wcol) ##1 s_coll_rd
        |=> (o_rdata[7:0] & $past(i_ram_wcol, 2)) == $past(i_ram_wcol, 2)) else $error("ram collision lost");
    a_per_coll: assert property ((|i_periph_wcol) ##1 s_coll_rd
        |=> (o_rdata[15:8] & $past(i_periph_wcol, 2)) == $past(i_periph_wcol, 2)) else $error("write collision lost");
    a_irq_cause: assert property (|o_block_irq |-> $past(o_xfer.valid && i_xfer_ack)
        && o_block_irq == 8'h01 << $past(o_xfer.channel)) else $error("interrupt without its transfer");
    a_irq_pulse: assert property (|o_block_irq |=> o_block_irq == 8'h00)
        else $error("interrupt longer than one cycle");
endmodule // dmacs_props

bind dmacs_top dmacs_props dmacs_props_inst (.i_clock, .i_rst_n, .i_bus, .o_rdata, .i_periph_req, .o_xfer,
    .i_xfer_ack, .i_periph_wcol, .i_ram_wcol, .o_block_irq);

// File: dv/dmacs_partner.sv
module dmacs_partner (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst_n,
    // Bench control
    input wire logic [6:0] i_line,
    input wire logic i_hold,
    input wire logic [3:0] i_delay,
    // Transfer port
    input wire dmacs_pkg::dmacs_xfer_type i_xfer,
    output logic [127:0] o_periph_req,
    output logic o_ack
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] wait_q;
    // One raised level line, the rest idle low
    assign o_periph_req = {127'h0, i_hold} << i_line;
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wait_q <= 4'h0;
            o_ack <= 1'b0;
        end else begin
            o_ack <= i_xfer.valid && !o_ack && wait_q == i_delay;
            wait_q <= (i_xfer.valid && !o_ack) ? wait_q + 4'h1 : 4'h0;
        end
    end
endmodule // dmacs_partner

// File: dv/dmacs_top_tb.sv
module dmacs_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clock = 1'b0;
    logic i_rst_n = 1'b0;
    dmacs_pkg::dmacs_bus_type i_bus = '0;
    logic [15:0] o_rdata;
    logic [127:0] i_periph_req;
    dmacs_pkg::dmacs_xfer_type o_xfer;
    logic i_xfer_ack;
    logic [7:0] i_periph_wcol = 8'h00;
    logic [7:0] i_ram_wcol = 8'h00;
    logic [7:0] o_block_irq;
    logic [6:0] line = 7'h00;
    logic hold = 1'b0;
    logic [3:0] delay = 4'h1;
    logic [7:0] irq_seen = 8'h00;
    int err_count = 0;
    int samples_checked = 0;
    dmacs_pkg::dmacs_xfer_type xlog[$];
    always #2.5 i_clock = ~i_clock;
    dmacs_top dmacs_top_inst (.i_clock, .i_rst_n, .i_bus, .o_rdata, .i_periph_req, .o_xfer, .i_xfer_ack,
        .i_periph_wcol, .i_ram_wcol, .o_block_irq);
    dmacs_partner dmacs_partner_inst (.i_clock, .i_rst_n, .i_line(line), .i_hold(hold), .i_delay(delay),
        .i_xfer(o_xfer), .o_periph_req(i_periph_req), .o_ack(i_xfer_ack));
    // Completed transfers and interrupts seen so far
    always @(posedge i_clock) begin
        irq_seen <= irq_seen | o_block_irq;
        if (o_xfer.valid && i_xfer_ack)
            xlog.push_back(o_xfer);
    end
    task automatic wrap_up();
        if (err_count == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [15:0] d);
        @(posedge i_clock);
        i_bus <= '{1'b1, 1'b0, a, d};
        @(posedge i_clock);
        i_bus <= '0;
    endtask
    task automatic rd(input logic [6:0] a, input logic [15:0] exp);
        @(posedge i_clock);
        i_bus <= '{1'b0, 1'b1, a, 16'h0000};
        i_ram_wcol <= 8'h00;
        i_periph_wcol <= 8'h00;
        @(posedge i_clock);
        i_bus <= '0;
        #1 chk(o_rdata, exp);
    endtask
    // Waits for n transfers, then a quiet span that must add none
    task automatic run(input int n);
        for (int i = 0; i < 300 && xlog.size() < n; i++)
            @(posedge i_clock);
        repeat (20) @(posedge i_clock);
        chk(16'(xlog.size()), 16'(n));
    endtask
    task automatic chk_x(input int i, input logic [15:0] ram, input logic [15:0] per, input logic [2:0] ch);
        chk(xlog[i].ram_addr, ram);
        chk(xlog[i].periph_addr, per);
        chk({13'h0000, xlog[i].channel}, {13'h0000, ch});
    endtask
    initial begin
        #20000;
        err_count++;
        wrap_up();
    end
    initial begin
        repeat (3) @(posedge i_clock);
        i_rst_n <= 1'b1;
        for (int c = 0; c < 8; c++)
            for (int r = 1; r < 6; r++)
                rd(7'(c * 8 + r), 16'h0000);
        rd(7'h40, 16'h0000);
        wr(7'h39, 16'h7fff);
        rd(7'h39, 16'h007f);
        wr(7'h3a, 16'ha5c3);
        rd(7'h3a, 16'ha5c3);
        wr(7'h3b, 16'h5a3c);
        rd(7'h3b, 16'h5a3c);
        wr(7'h3c, 16'hbeef);
        rd(7'h3c, 16'hbeef);
        wr(7'h3d, 16'hffff);
        rd(7'h3d, 16'h03ff);
        wr(7'h06, 16'hffff);
        rd(7'h06, 16'h0000);
        // Request-driven one-shot block, line raised while still off
        line <= 7'h55;
        hold <= 1'b1;
        wr(7'h0a, 16'h0100);
        wr(7'h0c, 16'h1234);
        wr(7'h0d, 16'h0002);
        wr(7'h09, 16'h0055);
        run(0);
        wr(7'h08, 16'h8001);
        run(3);
        for (int i = 0; i < 3; i++)
            chk_x(i, 16'h0100 + 16'(2 * i), 16'h1234, 3'h1);
        chk({15'h0000, xlog[0].to_periph}, 16'h0000);
        chk({8'h00, irq_seen}, 16'h0002);
        rd(7'h08, 16'h0001);
        hold <= 1'b0;
        // Forced single transfer, zero write must not cancel it
        xlog.delete();
        delay <= 4'h6;
        wr(7'h12, 16'h0400);
        wr(7'h15, 16'h0005);
        wr(7'h10, 16'h8000);
        wr(7'h11, 16'h8003);
        wr(7'h11, 16'h0003);
        rd(7'h11, 16'h8003);
        run(1);
        rd(7'h11, 16'h0003);
        chk_x(0, 16'h0400, 16'h0000, 3'h2);
        chk({8'h00, irq_seen}, 16'h0002);
        wr(7'h10, 16'h0000);
        // Ping-pong one-shot, one transfer per block
        xlog.delete();
        delay <= 4'h0;
        wr(7'h1a, 16'h0200);
        wr(7'h1b, 16'h0300);
        wr(7'h1c, 16'h00aa);
        wr(7'h19, 16'h0004);
        line <= 7'h04;
        hold <= 1'b1;
        wr(7'h18, 16'ha003);
        run(2);
        chk({15'h0000, xlog[1].to_periph}, 16'h0001);
        rd(7'h18, 16'h2003);
        chk_x(0, 16'h0200, 16'h00aa, 3'h3);
        chk_x(1, 16'h0300, 16'h00aa, 3'h3);
        chk({8'h00, irq_seen}, 16'h000a);
        hold <= 1'b0;
        // Collision flags: set by events, cleared only by zero writes
        @(posedge i_clock);
        i_ram_wcol <= 8'h20;
        i_periph_wcol <= 8'h04;
        rd(7'h40, 16'h0420);
        wr(7'h40, 16'hffff);
        rd(7'h40, 16'h0420);
        wr(7'h40, 16'hfbff);
        rd(7'h40, 16'h0020);
        // Event and zero write in one cycle: the event wins
        @(posedge i_clock);
        i_bus <= '{1'b1, 1'b0, 7'h40, 16'h0000};
        i_ram_wcol <= 8'h01;
        @(posedge i_clock);
        i_bus <= '0;
        i_ram_wcol <= 8'h00;
        rd(7'h40, 16'h0001);
        wr(7'h40, 16'h0000);
        wr(7'h40, 16'hffff);
        rd(7'h40, 16'h0000);
        wrap_up();
    end
endmodule // dmacs_top_tb
